// [hw/pctos_regs.vh]
// Register map, field positions, reset values and timing counts of the pixel clock output stage
`ifndef PCTOS_REGS_VH
`define PCTOS_REGS_VH

// Register byte offsets
`define PCTOS_CTRL_OFS 4'h0
`define PCTOS_RATE_OFS 4'h4
`define PCTOS_STAT_OFS 4'h8

// Control register fields
`define PCTOS_SRC_LSB 0
`define PCTOS_SRC_MSB 3
`define PCTOS_TDRV_BIT 4
`define PCTOS_BDRV_BIT 5
`define PCTOS_DIVB_LSB 8
`define PCTOS_DIVB_MSB 9
`define PCTOS_DIVD_LSB 10
`define PCTOS_DIVD_MSB 11

// Rate register fields
`define PCTOS_HALF_LSB 0
`define PCTOS_HALF_MSB 15
`define PCTOS_CUSTOM_BIT 16

// Timing source codes
`define PCTOS_SRC_HSYNC 4'h0
`define PCTOS_SRC_HBLANK 4'h1
`define PCTOS_SRC_VSYNC 4'h2
`define PCTOS_SRC_VBLANK 4'h3
`define PCTOS_SRC_FSYNC 4'h4
`define PCTOS_SRC_FDIGITAL 4'h5
`define PCTOS_SRC_ACTIVE 4'h6
`define PCTOS_SRC_CADENCE 4'h7
`define PCTOS_SRC_AUDIO 4'h8
`define PCTOS_SRC_CUSTOM1 4'h9
`define PCTOS_SRC_CUSTOM2 4'hA
`define PCTOS_SRC_CUSTOM3 4'hB
`define PCTOS_SRC_CUSTOM4 4'hC

// Divider codes
`define PCTOS_DIV_1 2'h0
`define PCTOS_DIV_2 2'h1
`define PCTOS_DIV_4 2'h2

// Reset values
`define PCTOS_CTRL_RST 32'h00000006
`define PCTOS_RATE_RST 32'h00000005

// Fundamental half periods in ref_clk cycles, picked by the low select bits
`define PCTOS_HALF_STD0 16'h0009
`define PCTOS_HALF_STD1 16'h0005
`define PCTOS_HALF_STD2 16'h0003
`define PCTOS_HALF_STD3 16'h0002

// AXI responses
`define PCTOS_RESP_OKAY 2'h0
`define PCTOS_RESP_SLVERR 2'h2

`endif

// [hw/pctos_clk_div.v]
// Glitch-free divider that turns fundamental half-period ticks into one output clock
`timescale 1ns/1ps
`default_nettype none

`include "pctos_regs.vh"

module pctos_clk_div (
    input wire ref_clk,
    input wire rst,
    input wire half_tick,
    input wire [1:0] div_code,
    output reg level
);

    reg [1:0] cnt;
    reg [1:0] cur_code;

    // Last count of fundamental half periods in an output half period, one less than the count, for a divider code
    function [1:0] last_half;
        input [1:0] code;
        begin
            if (code == `PCTOS_DIV_2) begin
                last_half = 2'h1;
            end else if (code == `PCTOS_DIV_1) begin
                last_half = 2'h0;
            end else begin
                last_half = 2'h3;
            end
        end
    endfunction

    // A new code is adopted only as the output rises, so every half period is whole
    always @(posedge ref_clk) begin
        if (rst) begin
            cnt <= 2'h0;
            level <= 1'b0;
            cur_code <= `PCTOS_DIV_1;
        end else if (half_tick) begin
            if (cnt == last_half(cur_code)) begin
                cnt <= 2'h0;
                level <= ~level;
                if (!level) begin
                    cur_code <= div_code;
                end
            end else begin
                cnt <= cnt + 2'h1;
            end
        end
    end

endmodule

`default_nettype wire

// [hw/pctos_top.v]
// Pixel clock and timing output stage with an AXI4-Lite register slave
// Registers
// Control: timing source, two drive strengths, two divider codes
// Rate: custom half period and its enable
// Status: select pins, enable, fundamental level, half length
// Unmapped words read zero and answer with a slave error
`timescale 1ns/1ps
`default_nettype none

`include "pctos_regs.vh"

module pctos_top (
    input wire ref_clk,
    input wire rst,
    input wire [5:0] picture_standard_select,
    input wire hsync,
    input wire hblank,
    input wire vsync,
    input wire vblank,
    input wire field_sync,
    input wire digital_field,
    input wire active_picture_flag,
    input wire ten_field_cadence_id,
    input wire audio_frame_sync_pulse,
    input wire [3:0] custom_timing,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg timing_out,
    output reg timing_out_oe,
    output reg timing_out_drive_high,
    output reg pixel_clock_out_b,
    output reg pixel_clock_out_b_drive_high,
    output reg pixel_clock_out_diff_p,
    output reg pixel_clock_out_diff_n,
    output reg pixel_clock_out_diff_oe
);

    reg [31:0] ctrl;
    reg [31:0] rate;
    reg [3:0] aw_addr;
    reg aw_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_held;
    reg [15:0] half_cnt;
    reg [15:0] half_len;
    reg fund_level;
    reg half_tick;
    reg timing_hold;
    reg next_timing;
    wire outputs_on;
    wire [15:0] next_half_len;
    wire div_b_level;
    wire div_d_level;
    wire b_rise;
    wire [15:0] custom_half;
    wire [31:0] status_word;

    // Select zero means no standard: pair and timing pin float, clock b held low
    assign outputs_on = (picture_standard_select != 6'h00);

    // Merge a write word into a register under its byte strobes
    // Bytes without a strobe keep their old contents
    function [31:0] merge_bytes;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            merge_bytes = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge_bytes[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // Word decode shared by the write and read channels
    function addr_hit;
        input [3:0] addr;
        input [3:0] ofs;
        begin
            addr_hit = (addr[3:2] == ofs[3:2]);
        end
    endfunction

    // Half period of the fundamental picked by the standard select pins
    // Only the two low select bits matter; higher codes reuse the same four rates
    function [15:0] std_half;
        input [5:0] sel;
        begin
            if (sel[1:0] == 2'h0) begin
                std_half = `PCTOS_HALF_STD0;
            end else if (sel[1:0] == 2'h1) begin
                std_half = `PCTOS_HALF_STD1;
            end else if (sel[1:0] == 2'h2) begin
                std_half = `PCTOS_HALF_STD2;
            end else begin
                std_half = `PCTOS_HALF_STD3;
            end
        end
    endfunction

    // A zero custom length is raised to one; the counter compare would toggle every cycle for either
    assign custom_half = (rate[`PCTOS_HALF_MSB:`PCTOS_HALF_LSB] == 16'h0000) ? 16'h0001 :
        rate[`PCTOS_HALF_MSB:`PCTOS_HALF_LSB];

    assign next_half_len = rate[`PCTOS_CUSTOM_BIT] ? custom_half :
        std_half(picture_standard_select);

    // Status snapshot; the fundamental level may have moved by the time it is read
    assign status_word = {half_len, 8'h00, fund_level, outputs_on, picture_standard_select};

    // Write address and data are taken independently, in either order
    // Ready pulses one cycle, so a valid still held is never taken twice
    always @(posedge ref_clk) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (aw_held && w_held && !s_axi_bvalid) begin
                w_held <= 1'b0;
            end
        end
    end

    // Register update and write response once both halves have arrived
    // A write to status or to an unmapped word changes no register
    always @(posedge ref_clk) begin
        if (rst) begin
            ctrl <= `PCTOS_CTRL_RST;
            rate <= `PCTOS_RATE_RST;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PCTOS_RESP_OKAY;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end else if (aw_held && w_held && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `PCTOS_RESP_OKAY;
                if (addr_hit(aw_addr, `PCTOS_CTRL_OFS)) begin
                    ctrl <= merge_bytes(ctrl, w_data, w_strb) & 32'h00000F3F;
                end else if (addr_hit(aw_addr, `PCTOS_RATE_OFS)) begin
                    rate <= merge_bytes(rate, w_data, w_strb) & 32'h0001FFFF;
                end else if (addr_hit(aw_addr, `PCTOS_STAT_OFS)) begin
                    s_axi_bresp <= `PCTOS_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `PCTOS_RESP_SLVERR;
                end
            end
        end
    end

    // Read channel: one read at a time, data answered the cycle after the address
    // A second address waits until the data of the first has been taken
    always @(posedge ref_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PCTOS_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `PCTOS_RESP_OKAY;
                if (addr_hit(s_axi_araddr, `PCTOS_CTRL_OFS)) begin
                    s_axi_rdata <= ctrl;
                end else if (addr_hit(s_axi_araddr, `PCTOS_RATE_OFS)) begin
                    s_axi_rdata <= rate;
                end else if (addr_hit(s_axi_araddr, `PCTOS_STAT_OFS)) begin
                    s_axi_rdata <= status_word;
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `PCTOS_RESP_SLVERR;
                end
            end
        end
    end

    // fundamental clock from the pin-selected rate, or the custom rate when enabled
    // new rate adopted only at a period boundary
    // Counter restarts at every toggle, so a shorter length never strands it
    always @(posedge ref_clk) begin
        if (rst) begin
            half_cnt <= 16'h0000;
            half_len <= `PCTOS_HALF_STD0;
            fund_level <= 1'b0;
            half_tick <= 1'b0;
        end else begin
            half_tick <= 1'b0;
            if (half_cnt + 16'h0001 >= half_len) begin
                half_cnt <= 16'h0000;
                half_tick <= 1'b1;
                fund_level <= ~fund_level;
                if (fund_level) begin
                    half_len <= next_half_len;
                end
            end else begin
                half_cnt <= half_cnt + 16'h0001;
            end
        end
    end

    // Each divider holds a new code until its own output rises
    // divider for output b
    pctos_clk_div u_div_b (
        .ref_clk(ref_clk),
        .rst(rst),
        .half_tick(half_tick),
        .div_code(ctrl[`PCTOS_DIVB_MSB:`PCTOS_DIVB_LSB]),
        .level(div_b_level)
    );

    // Shares the fundamental tick with output b, so the two stay phase related
    // divider for the differential pair
    pctos_clk_div u_div_d (
        .ref_clk(ref_clk),
        .rst(rst),
        .half_tick(half_tick),
        .div_code(ctrl[`PCTOS_DIVD_MSB:`PCTOS_DIVD_LSB]),
        .level(div_d_level)
    );

    // Spare codes fall back to the active flag rather than a fixed level
    // source multiplexer
    always @* begin
        case (ctrl[`PCTOS_SRC_MSB:`PCTOS_SRC_LSB])
            `PCTOS_SRC_HSYNC: next_timing = hsync;
            `PCTOS_SRC_HBLANK: next_timing = hblank;
            `PCTOS_SRC_VSYNC: next_timing = vsync;
            `PCTOS_SRC_VBLANK: next_timing = vblank;
            `PCTOS_SRC_FSYNC: next_timing = field_sync;
            `PCTOS_SRC_FDIGITAL: next_timing = digital_field;
            `PCTOS_SRC_CADENCE: next_timing = ten_field_cadence_id;
            `PCTOS_SRC_AUDIO: next_timing = audio_frame_sync_pulse;
            `PCTOS_SRC_CUSTOM1: next_timing = custom_timing[0];
            `PCTOS_SRC_CUSTOM2: next_timing = custom_timing[1];
            `PCTOS_SRC_CUSTOM3: next_timing = custom_timing[2];
            `PCTOS_SRC_CUSTOM4: next_timing = custom_timing[3];
            // active picture flag is the reset source and the fallback
            default: next_timing = active_picture_flag;
        endcase
    end

    // Rising edge of the fundamental, the instant the timing output may move
    // Tick and level are registered on the same edge, so this is the first cycle the fundamental is high
    assign b_rise = half_tick && fund_level;

    // At quarter rate on both clocks a move may fall between clock edges
    // timing sampled only on fundamental rising edges
    always @(posedge ref_clk) begin
        if (rst) begin
            timing_hold <= 1'b0;
        end else if (b_rise) begin
            timing_hold <= next_timing;
        end
    end

    // All pins share one register stage so the timing stays in step with the clocks
    // The pair keeps complementary levels while floated; only the enable drops
    always @(posedge ref_clk) begin
        if (rst) begin
            timing_out <= 1'b0;
            timing_out_oe <= 1'b0;
            timing_out_drive_high <= 1'b0;
            pixel_clock_out_b <= 1'b0;
            pixel_clock_out_b_drive_high <= 1'b0;
            pixel_clock_out_diff_p <= 1'b0;
            pixel_clock_out_diff_n <= 1'b1;
            pixel_clock_out_diff_oe <= 1'b0;
        end else begin
            timing_out <= timing_hold;
            // float timing pin when no standard
            timing_out_oe <= outputs_on;
            timing_out_drive_high <= ctrl[`PCTOS_TDRV_BIT];
            // output b held low, never floated
            pixel_clock_out_b <= outputs_on & div_b_level;
            pixel_clock_out_b_drive_high <= ctrl[`PCTOS_BDRV_BIT];
            pixel_clock_out_diff_p <= div_d_level;
            pixel_clock_out_diff_n <= ~div_d_level;
            pixel_clock_out_diff_oe <= outputs_on;
        end
    end

endmodule

`default_nettype wire

// [tb/pctos_top_asserts.sv]
// Port-level checker for the pixel clock output stage
`timescale 1ns/1ps
`default_nettype none
module pctos_top_asserts (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [5:0] picture_standard_select,
    input wire logic timing_out,
    input wire logic timing_out_oe,
    input wire logic timing_out_drive_high,
    input wire logic pixel_clock_out_b,
    input wire logic pixel_clock_out_b_drive_high,
    input wire logic pixel_clock_out_diff_p,
    input wire logic pixel_clock_out_diff_n,
    input wire logic pixel_clock_out_diff_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Select at zero over two edges, so the registered outputs have caught up
    sequence s_off;
        picture_standard_select == 6'h00 ##1 picture_standard_select == 6'h00;
    endsequence
    // Clock b starts a high phase while the outputs stay enabled
    sequence s_b_rise;
        $rose(pixel_clock_out_b) && picture_standard_select != 6'h00;
    endsequence
    // Timing moves while driven; needs one clock not at quarter rate
    sequence s_tim_move;
        $changed(timing_out) && $past(timing_out_oe) && timing_out_oe;
    endsequence
    property p_tim_float;
        s_off |-> !timing_out_oe;
    endproperty
    a_tim_float: assert property (p_tim_float) else $error("timing driven while off");
    property p_diff_float;
        s_off |-> !pixel_clock_out_diff_oe;
    endproperty
    a_diff_float: assert property (p_diff_float) else $error("pair driven while off");
    property p_b_low;
        s_off |-> !pixel_clock_out_b;
    endproperty
    a_b_low: assert property (p_b_low) else $error("clock b not low while off");
    property p_diff_pair;
        pixel_clock_out_diff_n != pixel_clock_out_diff_p;
    endproperty
    a_diff_pair: assert property (p_diff_pair) else $error("pair legs not opposite");
    property p_tdrv_rst;
        $fell(rst) |-> !timing_out_drive_high;
    endproperty
    a_tdrv_rst: assert property (p_tdrv_rst) else $error("timing drive high at reset");
    property p_bdrv_rst;
        $fell(rst) |-> !pixel_clock_out_b_drive_high;
    endproperty
    a_bdrv_rst: assert property (p_bdrv_rst) else $error("clock b drive high at reset");
    property p_no_runt;
        s_b_rise |=> pixel_clock_out_b;
    endproperty
    a_no_runt: assert property (p_no_runt) else $error("runt high phase on clock b");
    property p_sync;
        s_tim_move |-> $changed(pixel_clock_out_b) || $changed(pixel_clock_out_diff_p);
    endproperty
    a_sync: assert property (p_sync) else $error("timing moved off a clock edge");
endmodule
bind pctos_top pctos_top_asserts i_chk (.ref_clk, .rst, .picture_standard_select,
    .timing_out, .timing_out_oe, .timing_out_drive_high, .pixel_clock_out_b,
    .pixel_clock_out_b_drive_high, .pixel_clock_out_diff_p, .pixel_clock_out_diff_n,
    .pixel_clock_out_diff_oe);
`default_nettype wire

// [tb/pctos_sink.sv]
// Downstream consumer: measures clock periods and samples timing on clock b
`timescale 1ns/1ps
`default_nettype none
module pctos_sink (
    input wire logic ref_clk,
    input wire logic clk_b,
    input wire logic clk_d,
    input wire logic timing,
    output logic [15:0] per_b,
    output logic [15:0] per_d,
    output logic seen
);
    logic [15:0] cnt_b;
    logic [15:0] cnt_d;
    logic old_b;
    logic old_d;
    // Count ref cycles between rises; a short period shows as a small count
    always @(posedge ref_clk) begin
        old_b <= clk_b;
        old_d <= clk_d;
        cnt_b <= (clk_b && !old_b) ? 16'h0001 : cnt_b + 16'h0001;
        cnt_d <= (clk_d && !old_d) ? 16'h0001 : cnt_d + 16'h0001;
        if (clk_b && !old_b) begin
            per_b <= cnt_b;
            seen <= timing;
        end
        if (clk_d && !old_d) begin
            per_d <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the pixel clock output stage
`timescale 1ns/1ps
`default_nettype none
`include "pctos_regs.vh"
module tb;
    typedef struct packed {logic [11:0] ctrl; logic [5:0] sel;
        logic [15:0] pb; logic [15:0] pd;} pctos_row;
    // Divider and rate rows: control, select, period of b, period of pair
    pctos_row rows [4] = '{'{12'h006, 6'h01, 16'h000A, 16'h000A},
        '{12'h106, 6'h02, 16'h000C, 16'h0006}, '{12'h806, 6'h03, 16'h0004, 16'h0010},
        '{12'h506, 6'h04, 16'h0024, 16'h0024}};
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] sel = 6'h01;
    logic [12:0] src = 13'h0040;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [1:0] br;
    wire awready, wready, bvalid, arready, rvalid, t_out, t_oe, t_drv, clk_b, b_drv;
    wire d_p, d_n, d_oe, seen;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] per_b, per_d;
    int errors = 0;
    int checked = 0;
    int k;
    pctos_top i_dut (.ref_clk(ref_clk), .rst(rst), .picture_standard_select(sel),
        .hsync(src[0]), .hblank(src[1]), .vsync(src[2]), .vblank(src[3]),
        .field_sync(src[4]), .digital_field(src[5]), .active_picture_flag(src[6]),
        .ten_field_cadence_id(src[7]), .audio_frame_sync_pulse(src[8]),
        .custom_timing(src[12:9]), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .timing_out(t_out), .timing_out_oe(t_oe), .timing_out_drive_high(t_drv),
        .pixel_clock_out_b(clk_b), .pixel_clock_out_b_drive_high(b_drv),
        .pixel_clock_out_diff_p(d_p), .pixel_clock_out_diff_n(d_n),
        .pixel_clock_out_diff_oe(d_oe));
    pctos_sink i_sink (.ref_clk(ref_clk), .clk_b(clk_b), .clk_d(d_p), .timing(t_out),
        .per_b(per_b), .per_d(per_d), .seen(seen));
    // Compare with four-state equality so an unknown matches only an unknown in the same bit
    task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
        checked++;
        if (seen_v !== exp_v) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask
    task automatic give_verdict;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Write: address and data offered together, each dropped once taken
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            br = bresp;
        end while (!bvalid && n < 40);
        bready <= 1'b0;
        if (n >= 40) begin
            errors++;
            give_verdict();
        end
    endtask
    // Read: data and response taken at the edge where rvalid is seen
    task automatic axr(input logic [3:0] a);
        int n;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            if (arready) arvalid <= 1'b0;
            rd = rdata;
            rr = rresp;
        end while (!rvalid && n < 40);
        rready <= 1'b0;
        if (n >= 40) begin
            errors++;
            give_verdict();
        end
    endtask
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        chk({t_drv, b_drv, d_n}, 32'h00000001);
        rst <= 1'b0;
        axr(`PCTOS_CTRL_OFS);
        chk(rd, `PCTOS_CTRL_RST);
        axr(`PCTOS_RATE_OFS);
        chk(rd, `PCTOS_RATE_RST);
        axr(4'hC);
        chk(rr, `PCTOS_RESP_SLVERR);
        chk(rd, 32'h00000000);
        idle(30);
        chk(t_out, 1'b1);
        src <= 13'h1FBF;
        idle(30);
        chk(t_out, 1'b0);
        $display("test reset done");
        // Every source code, the spare codes falling back to the active flag
        for (int c = 0; c < 16; c++) begin
            k = (c > 12) ? 6 : c;
            axw(`PCTOS_CTRL_OFS, 32'(c));
            src <= 13'h0001 << k;
            idle(30);
            chk(t_out, 1'b1);
            chk(seen, 1'b1);
            src <= ~(13'h0001 << k);
            idle(30);
            chk(t_out, 1'b0);
        end
        $display("test sources done");
        src <= 13'h0040;
        foreach (rows[i]) begin
            sel <= rows[i].sel;
            axw(`PCTOS_CTRL_OFS, {20'h00000, rows[i].ctrl});
            idle(200);
            chk(per_b, rows[i].pb);
            chk(per_d, rows[i].pd);
            chk(t_out, 1'b1);
        end
        $display("test dividers done");
        axw(`PCTOS_CTRL_OFS, 32'h00000036);
        axw(`PCTOS_RATE_OFS, 32'h00010004);
        chk(br, `PCTOS_RESP_OKAY);
        axw(4'hC, 32'hFFFFFFFF);
        chk(br, `PCTOS_RESP_SLVERR);
        axw(`PCTOS_STAT_OFS, 32'hFFFFFFFF);
        chk(br, `PCTOS_RESP_OKAY);
        axr(`PCTOS_CTRL_OFS);
        chk(rd, 32'h00000036);
        idle(100);
        chk({t_drv, b_drv}, 32'h00000003);
        chk({t_oe, d_oe}, 32'h00000003);
        chk(per_b, 16'h0008);
        chk(per_d, 16'h0008);
        axr(`PCTOS_STAT_OFS);
        chk(rd & 32'hFFFF007F, 32'h00040044);
        $display("test custom rate done");
        // Reset in mid-run: programmed settings must fall back to their defaults
        rst <= 1'b1;
        idle(4);
        chk({t_drv, b_drv, t_oe, d_oe, d_n}, 32'h00000001);
        rst <= 1'b0;
        axr(`PCTOS_CTRL_OFS);
        chk(rd, `PCTOS_CTRL_RST);
        axr(`PCTOS_RATE_OFS);
        chk(rd, `PCTOS_RATE_RST);
        idle(60);
        chk(per_b, 16'h0012);
        chk(per_d, 16'h0012);
        chk(t_out, 1'b1);
        $display("test mid-run reset done");
        sel <= 6'h00;
        idle(4);
        repeat (20) begin
            @(posedge ref_clk);
            chk({t_oe, clk_b, d_oe}, 32'h00000000);
        end
        $display("test outputs off done");
        give_verdict();
    end
endmodule
`default_nettype wire
